/* src/pp_pkg.sv */
package pp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PORT_W = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_DATA  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MODE  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_ISTAT = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_EPP   = 8'h18;

	// control register fields
	localparam int CTRL_W      = 6;
	localparam int CTRL_LATCH  = 0;
	localparam int CTRL_FEED   = 1;
	localparam int CTRL_RESET  = 2;
	localparam int CTRL_SELECT = 3;
	localparam int CTRL_IRQEN  = 4;
	localparam int CTRL_DIR    = 5;

	// status register fields
	localparam int STAT_WAIT   = 0;
	localparam int STAT_FAULT  = 3;
	localparam int STAT_ONLINE = 4;
	localparam int STAT_EMPTY  = 5;
	localparam int STAT_RCPT   = 6;
	localparam int STAT_BUSY   = 7;

	// event bits of status and mask
	localparam int IRQ_W     = 4;
	localparam int IRQ_RCPT  = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_DONE  = 2;
	localparam int IRQ_TMO   = 3;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST  = 6'h20;
	localparam logic [PORT_W-1:0] DATA_RST  = 8'h00;
	localparam logic [IRQ_W-1:0]  IMASK_RST = 4'h0;
	localparam logic [IRQ_W-1:0]  ISTAT_RST = 4'h0;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int EPP_TMO_NS    = 4000;
	localparam int EPP_TMO_CYC   = EPP_TMO_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		EPP_IDLE,
		EPP_STROBE,
		EPP_RELEASE
	} pp_epp_state_t;
endpackage : pp_pkg

/* src/pp_epp_if.sv */
interface pp_epp_if;
	import pp_pkg::*;
	logic              req;
	logic              wr;
	logic [PORT_W-1:0] din;
	logic              wait_in;
	logic [PORT_W-1:0] rdata;
	logic              done;
	logic              tmo;
	logic              data_stb_n;
	logic              drive;

	modport ctl (
		output req, wr, din, wait_in,
		input  rdata, done, tmo, data_stb_n, drive
	);
	modport eng (
		input  req, wr, din, wait_in,
		output rdata, done, tmo, data_stb_n, drive
	);
endinterface : pp_epp_if

/* src/pp_sync.sv */
module pp_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	if (W < 1) $error("pp_sync: width must be at least one");

	// two-stage synchroniser, meta read only by q
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : pp_sync

/* src/pp_epp.sv */
module pp_epp import pp_pkg::*; #(
	parameter int TMO = EPP_TMO_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	pp_epp_if.eng     ep
);
	localparam int TW = $clog2(TMO + 1);
	localparam logic [TW-1:0] CNT_LAST = TW'(TMO - 1);

	pp_epp_state_t     state;
	pp_epp_state_t     next_state;
	logic [TW-1:0]     cnt;
	logic [TW-1:0]     next_cnt;
	logic [PORT_W-1:0] next_rdata;
	logic              next_done;
	logic              next_tmo;
	logic              next_stb_n;
	logic              next_drive;

	if (TMO < 2) $error("pp_epp: timeout must be at least two cycles");

	// strobe low, wait for peer busy high, release, wait for busy low
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_rdata = ep.rdata;
		next_done  = 1'b0;
		next_tmo   = 1'b0;
		next_stb_n = 1'b1;
		next_drive = ep.drive;
		unique case (state)
			EPP_IDLE: begin
				if (ep.req) begin
					next_state = EPP_STROBE;
					next_cnt   = '0;
					next_stb_n = 1'b0;
					next_drive = ep.wr;
				end
			end
			EPP_STROBE: begin
				next_stb_n = 1'b0;
				next_cnt   = cnt + 1'b1;
				if (ep.wait_in) begin
					next_state = EPP_RELEASE;
					next_stb_n = 1'b1;
					next_rdata = ep.din;
					next_cnt   = '0;
				end else if (cnt == CNT_LAST) begin
					next_state = EPP_IDLE;
					next_stb_n = 1'b1;
					next_done  = 1'b1;
					next_tmo   = 1'b1;
					next_drive = 1'b0;
				end
			end
			EPP_RELEASE: begin
				next_cnt = cnt + 1'b1;
				if (!ep.wait_in || cnt == CNT_LAST) begin
					next_state = EPP_IDLE;
					next_done  = 1'b1;
					next_tmo   = ep.wait_in;
					next_drive = 1'b0;
				end
			end
			default: next_state = EPP_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state         <= EPP_IDLE;
			cnt           <= '0;
			ep.rdata      <= DATA_RST;
			ep.done       <= 1'b0;
			ep.tmo        <= 1'b0;
			ep.data_stb_n <= 1'b1;
			ep.drive      <= 1'b0;
		end else begin
			state         <= next_state;
			cnt           <= next_cnt;
			ep.rdata      <= next_rdata;
			ep.done       <= next_done;
			ep.tmo        <= next_tmo;
			ep.data_stb_n <= next_stb_n;
			ep.drive      <= next_drive;
		end
	end
endmodule : pp_epp

/* src/pp_port.sv */
// Notes on behaviour
// - select output is the inverse of control bit 3
// - printer reset output follows control bit 2 directly; low resets
// - line feed output is the inverse of control bit 1; in enhanced mode it carries the data strobe
// - data latch output is the inverse of control bit 0
// - status bit 7 reads the inverted busy input
// - status bit 6 reads the receipt input as is
// - status bit 5 reads the media empty input as is
// - status bit 4 reads the printer online input as is
// - status bit 3 reads the fault input as is, low means fault
// - control bit 4 enables the port interrupt output
// - port data lines form a bidirectional bus to the peripheral
// - in enhanced mode host wait line held low until transfer ends
module pp_port import pp_pkg::*; #(
	parameter int EPP_TMO = EPP_TMO_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic                   pready,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pslverr,
	output logic                   printer_select_out,
	output logic                   printer_reset_out,
	output logic                   auto_line_feed_out,
	output logic                   data_latch_out,
	input  wire logic              busy_in,
	input  wire logic              receipt_in,
	input  wire logic              media_empty_in,
	input  wire logic              printer_online_in,
	input  wire logic              fault_in,
	input  wire logic [PORT_W-1:0] port_data_bus_in,
	output logic      [PORT_W-1:0] port_data_bus_out,
	output logic                   port_data_bus_oe_n,
	output logic                   port_irq_out,
	input  wire logic              host_wait_line_in,
	output logic                   host_wait_line_out,
	output logic                   host_wait_line_oe_n
);
	localparam int WAIT_LIM = 1000;
	localparam int IN_W     = PORT_W + 6;

	logic [IN_W-1:0]   in_s;
	logic              wait_s;
	logic              busy_s;
	logic              rcpt_s;
	logic              empty_s;
	logic              online_s;
	logic              fault_s;
	logic [PORT_W-1:0] din_s;

	logic [PORT_W-1:0] data_out;
	logic [PORT_W-1:0] next_data_out;
	logic [CTRL_W-1:0] ctrl;
	logic [CTRL_W-1:0] next_ctrl;
	logic              mode_epp;
	logic              next_mode_epp;
	logic [IRQ_W-1:0]  imask;
	logic [IRQ_W-1:0]  next_imask;
	logic [IRQ_W-1:0]  istat;
	logic [IRQ_W-1:0]  next_istat;
	logic [IRQ_W-1:0]  ev;
	logic [IRQ_W-1:0]  w1c;
	logic              epp_pend;
	logic              next_epp_pend;
	logic              epp_req;
	logic              rcpt_d;
	logic              fault_d;
	logic              next_pready;
	logic              next_pslverr;
	logic [DATA_W-1:0] next_prdata;
	logic [PORT_W-1:0] rd_byte;
	logic [PORT_W-1:0] stat_byte;
	logic              mapped;
	logic              setup_acc;
	logic              wr_acc;
	logic              epp_hit;
	logic              next_oe_n;
	logic              next_feed;

	if (EPP_TMO < 2 || EPP_TMO > 400)
		$error("pp_port: EPP_TMO must lie in 2..400");

	pp_sync #(.W(IN_W)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({host_wait_line_in, busy_in, receipt_in, media_empty_in,
		           printer_online_in, fault_in, port_data_bus_in}),
		.q       (in_s)
	);
	assign {wait_s, busy_s, rcpt_s, empty_s, online_s, fault_s, din_s} = in_s;

	pp_epp_if ep ();
	assign ep.req     = epp_req;
	assign ep.wr      = pwrite;
	assign ep.din     = din_s;
	assign ep.wait_in = busy_s;

	pp_epp #(.TMO(EPP_TMO)) u_epp (
		.pclk    (pclk),
		.presetn (presetn),
		.ep      (ep)
	);

	assign setup_acc = psel & penable & ~pready;
	assign wr_acc    = psel & penable & pready & pwrite;
	assign epp_hit   = mode_epp & (paddr == OFF_EPP);

	// status byte from synchronised printer lines
	always_comb begin
		stat_byte              = '0;
		stat_byte[STAT_BUSY]   = ~busy_s;
		stat_byte[STAT_RCPT]   = rcpt_s;
		stat_byte[STAT_EMPTY]  = empty_s;
		stat_byte[STAT_ONLINE] = online_s;
		stat_byte[STAT_FAULT]  = fault_s;
		stat_byte[STAT_WAIT]   = wait_s;
	end

	// read decode
	always_comb begin
		rd_byte = '0;
		mapped  = 1'b1;
		case (paddr)
			OFF_DATA:  rd_byte = din_s;
			OFF_STAT:  rd_byte = stat_byte;
			OFF_CTRL:  rd_byte = {{(PORT_W-CTRL_W){1'b0}}, ctrl};
			OFF_MODE:  rd_byte = {{(PORT_W-1){1'b0}}, mode_epp};
			OFF_ISTAT: rd_byte = {{(PORT_W-IRQ_W){1'b0}}, istat};
			OFF_IMASK: rd_byte = {{(PORT_W-IRQ_W){1'b0}}, imask};
			OFF_EPP:   rd_byte = din_s;
			default:   mapped  = 1'b0;
		endcase
	end

	// events: receipt and fault falling edges, transfer end, timeout
	always_comb begin
		ev            = '0;
		ev[IRQ_RCPT]  = rcpt_d & ~rcpt_s;
		ev[IRQ_FAULT] = fault_d & ~fault_s;
		ev[IRQ_DONE]  = ep.done & ~ep.tmo;
		ev[IRQ_TMO]   = ep.done & ep.tmo;
	end

	always_comb begin
		next_data_out = data_out;
		next_ctrl     = ctrl;
		next_mode_epp = mode_epp;
		next_imask    = imask;
		next_epp_pend = epp_pend;
		next_pready   = 1'b0;
		next_pslverr  = 1'b0;
		next_prdata   = prdata;
		epp_req       = 1'b0;
		w1c           = '0;
		if (setup_acc) begin
			if (epp_hit) begin
				if (!epp_pend) begin
					epp_req       = 1'b1;
					next_epp_pend = 1'b1;
					if (pwrite)
						next_data_out = pwdata[PORT_W-1:0];
				end
				if (ep.done) begin
					next_epp_pend = 1'b0;
					next_pready   = 1'b1;
					next_pslverr  = ep.tmo;
					next_prdata   = {24'h000000, pwrite ? DATA_RST : ep.rdata};
				end
			end else begin
				next_pready  = 1'b1;
				next_pslverr = ~mapped;
				next_prdata  = pwrite ? prdata : {24'h000000, rd_byte};
			end
		end
		if (wr_acc) begin
			case (paddr)
				OFF_DATA:  next_data_out = pwdata[PORT_W-1:0];
				OFF_CTRL:  next_ctrl     = pwdata[CTRL_W-1:0];
				OFF_MODE:  next_mode_epp = pwdata[0];
				OFF_IMASK: next_imask    = pwdata[IRQ_W-1:0];
				OFF_ISTAT: w1c           = pwdata[IRQ_W-1:0];
				default:   ;
			endcase
		end
		// set wins over a clear in the same cycle
		next_istat = (istat & ~w1c) | ev;
	end

	// pin values from the next register state, so they move with the write; enhanced mode feed and bus enable use the engine's current outputs
	always_comb begin
		if (next_mode_epp) begin
			next_feed = ep.data_stb_n;
			next_oe_n = ~(ep.drive | (epp_req & pwrite));
		end else begin
			next_feed = ~next_ctrl[CTRL_FEED];
			next_oe_n = next_ctrl[CTRL_DIR];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out            <= DATA_RST;
			ctrl                <= CTRL_RST;
			mode_epp            <= 1'b0;
			imask               <= IMASK_RST;
			istat               <= ISTAT_RST;
			epp_pend            <= 1'b0;
			rcpt_d              <= 1'b0;
			fault_d             <= 1'b0;
			pready              <= 1'b0;
			pslverr             <= 1'b0;
			prdata              <= '0;
			printer_select_out  <= 1'b1;
			printer_reset_out   <= 1'b0;
			auto_line_feed_out  <= 1'b1;
			data_latch_out      <= 1'b1;
			port_data_bus_out   <= DATA_RST;
			port_data_bus_oe_n  <= 1'b1;
			port_irq_out        <= 1'b0;
			host_wait_line_out  <= 1'b0;
			host_wait_line_oe_n <= 1'b1;
		end else begin
			data_out            <= next_data_out;
			ctrl                <= next_ctrl;
			mode_epp            <= next_mode_epp;
			imask               <= next_imask;
			istat               <= next_istat;
			epp_pend            <= next_epp_pend;
			rcpt_d              <= rcpt_s;
			fault_d             <= fault_s;
			pready              <= next_pready;
			pslverr             <= next_pslverr;
			prdata              <= next_prdata;
			printer_select_out  <= ~next_ctrl[CTRL_SELECT];
			printer_reset_out   <= next_ctrl[CTRL_RESET];
			auto_line_feed_out  <= next_feed;
			data_latch_out      <= ~next_ctrl[CTRL_LATCH];
			port_data_bus_out   <= next_data_out;
			port_data_bus_oe_n  <= next_oe_n;
			port_irq_out        <= next_ctrl[CTRL_IRQEN]
				& |(next_istat & next_imask);
			host_wait_line_out  <= 1'b0;
			host_wait_line_oe_n <= ~next_epp_pend;
		end
	end

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence ctrl_write;
		wr_acc && paddr == OFF_CTRL;
	endsequence

	a_select_follows: assert property (
		ctrl_write |=> printer_select_out == !$past(pwdata[CTRL_SELECT])
	) else $error("select output does not follow control write");

	a_reset_follows: assert property (
		ctrl_write |=> printer_reset_out == $past(pwdata[CTRL_RESET])
	) else $error("printer reset output does not follow control write");

	a_feed_follows: assert property (
		ctrl_write ##0 !mode_epp
		|=> auto_line_feed_out == !$past(pwdata[CTRL_FEED])
	) else $error("line feed output does not follow control write");

	a_latch_stable: assert property (
		ctrl_write |=> data_latch_out == !$past(pwdata[CTRL_LATCH])
			##1 (data_latch_out == !ctrl[CTRL_LATCH])
	) else $error("data latch output wrong after control write");

	a_busy_reads: assert property (
		setup_acc && !epp_hit && !pwrite && paddr == OFF_STAT
		|=> pready && prdata[STAT_BUSY] == !$past(busy_s)
	) else $error("busy status bit wrong");

	a_status_bits: assert property (
		setup_acc && !epp_hit && !pwrite && paddr == OFF_STAT
		|=> prdata[STAT_RCPT:STAT_FAULT] == $past({rcpt_s, empty_s,
			online_s, fault_s})
	) else $error("printer status bits wrong");

	a_irq_gated: assert property (
		!ctrl[CTRL_IRQEN] |-> !port_irq_out
	) else $error("interrupt output high while disabled");

	a_irq_raised: assert property (
		ctrl[CTRL_IRQEN] && |(istat & imask) |-> port_irq_out
	) else $error("interrupt output low with enabled event");

	a_data_driven: assert property (
		!mode_epp && !ctrl[CTRL_DIR]
		|-> !port_data_bus_oe_n && port_data_bus_out == data_out
	) else $error("port data bus not driven in output direction");

	a_wait_held: assert property (
		epp_pend |-> !host_wait_line_oe_n && !pready
	) else $error("host wait line released during transfer");

	a_wait_bounded: assert property (
		$rose(epp_pend) |-> ##[1:WAIT_LIM] $fell(epp_pend) && pready
	) else $error("enhanced transfer did not finish in time");

	c_ctrl_write: cover property (ctrl_write);
	c_epp_done: cover property (ep.done && !ep.tmo);
	c_epp_tmo: cover property (ep.done && ep.tmo);
	c_irq_rise: cover property ($rose(port_irq_out));
endmodule : pp_port

/* test/pp_printer.sv */
module pp_printer (
	input  wire logic       pclk,
	input  wire logic       epp_en,
	input  wire logic [3:0] dly,
	input  wire logic [4:0] lvl,
	input  wire logic [7:0] rd_byte,
	input  wire logic       strobe_n,
	input  wire logic       oe_n,
	output logic            busy,
	output logic      [3:0] pins,
	output logic      [7:0] data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       hs = 1'b0;
	logic [3:0] cnt = 4'h0;
	// ack a strobe after dly cycles, finish dly cycles after release
	always_ff @(posedge pclk) begin
		if (!epp_en) begin
			hs <= 1'b0;
			cnt <= 4'h0;
		end else if (strobe_n != hs) begin
			cnt <= 4'h0;
		end else if (cnt == dly) begin
			hs <= !strobe_n;
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	assign busy = epp_en ? hs : lvl[4];
	assign pins = lvl[3:0];
	// released bus shows the byte as is, driven bus the inverse byte
	assign data = oe_n ? rd_byte : ~rd_byte;
endmodule : pp_printer

/* test/tb.sv */
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb import pp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00, rb = 8'hA5, pdm, port_data_bus_in;
	logic [31:0] pwdata = 32'h0, seed = 32'h06E0, rd, v, prdata;
	logic [7:0]  port_data_bus_out;
	logic        pready, pslverr, printer_select_out, printer_reset_out;
	logic        auto_line_feed_out, data_latch_out, busy_in, receipt_in;
	logic        media_empty_in, printer_online_in, fault_in;
	logic        port_data_bus_oe_n, port_irq_out, host_wait_line_in;
	logic        host_wait_line_out, host_wait_line_oe_n, err, saw;
	logic        epp_en = 0;
	logic [3:0]  dly = 4'h0;
	logic [4:0]  lvl = 5'h12;
	int          error_cnt = 0, checked = 0;

	pp_port #(.EPP_TMO(16)) u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.printer_select_out, .printer_reset_out, .auto_line_feed_out,
		.data_latch_out, .busy_in, .receipt_in, .media_empty_in,
		.printer_online_in, .fault_in, .port_data_bus_in,
		.port_data_bus_out, .port_data_bus_oe_n, .port_irq_out,
		.host_wait_line_in, .host_wait_line_out, .host_wait_line_oe_n);
	pp_printer u_prn (.pclk, .epp_en, .dly, .lvl, .rd_byte(rb),
		.strobe_n(auto_line_feed_out), .oe_n(port_data_bus_oe_n),
		.busy(busy_in), .data(pdm), .pins({receipt_in, media_empty_in,
		printer_online_in, fault_in}));
	assign port_data_bus_in = port_data_bus_oe_n ? pdm : port_data_bus_out;
	// open drain with pull-up
	assign host_wait_line_in = host_wait_line_oe_n | host_wait_line_out;

	initial forever #5 pclk = ~pclk;

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [3:0] pins_of(input logic [5:0] c);
		return {~c[3], c[2], ~c[1], ~c[0]};
	endfunction : pins_of
	function automatic logic [31:0] stat_of(input logic [4:0] s);
		return {24'h0, ~s[4], s[3:0], 3'b001};
	endfunction : stat_of

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		saw = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			if (host_wait_line_oe_n === 1'b0) saw = 1'b1;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic irq_is(input logic e);
		repeat (2) @(posedge pclk);
		#1;
		`CHK("irq", e, port_irq_out)
	endtask : irq_is
	task automatic tally_and_finish();
		if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		`CHK("rst pins", pins_of(6'h20), {printer_select_out, printer_reset_out, auto_line_feed_out, data_latch_out})
		for (int i = 0; i < 24; i++) begin
			v = i < 2 ? {26'h0, {6{i[0]}}} : rnd() & 32'h3F;
			apb(1'b1, OFF_CTRL, v);
			#1;
			`CHK("pins", pins_of(v[5:0]), {printer_select_out, printer_reset_out, auto_line_feed_out, data_latch_out})
			`CHK("oe_n", v[5], port_data_bus_oe_n)
			`CHK("wait", 1'b0, saw)
			apb(1'b0, OFF_CTRL, 32'h0);
			`CHK("ctrl", v, rd)
		end
		for (int i = 0; i < 16; i++) begin
			v = i < 2 ? {32{i[0]}} : rnd();
			lvl <= v[4:0];
			repeat (3) @(posedge pclk);
			apb(1'b0, OFF_STAT, 32'h0);
			`CHK("stat", stat_of(lvl), rd)
		end
		for (int i = 0; i < 4; i++) begin
			v = rnd() & 32'hFF;
			apb(1'b1, OFF_CTRL, 32'h04);
			apb(1'b1, OFF_DATA, v);
			#1;
			`CHK("pd out", v[7:0], port_data_bus_out)
			apb(1'b0, OFF_DATA, 32'h0);
			`CHK("pd loop", v, rd)
			apb(1'b1, OFF_CTRL, 32'h24);
			rb <= v[15:8] ^ 8'h5A;
			apb(1'b0, OFF_DATA, 32'h0);
			`CHK("pd in", {24'h0, rb}, rd)
		end
		lvl <= 5'h09;
		apb(1'b1, OFF_ISTAT, 32'hF);
		apb(1'b1, OFF_IMASK, 32'h3);
		apb(1'b1, OFF_CTRL, 32'h34);
		lvl <= 5'h00;
		repeat (4) @(posedge pclk);
		irq_is(1'b1);
		apb(1'b0, OFF_ISTAT, 32'h0);
		`CHK("istat", 32'h3, rd)
		apb(1'b1, OFF_CTRL, 32'h24);
		irq_is(1'b0);
		apb(1'b1, OFF_CTRL, 32'h34);
		irq_is(1'b1);
		apb(1'b1, OFF_IMASK, 32'h0);
		irq_is(1'b0);
		apb(1'b1, OFF_IMASK, 32'h3);
		apb(1'b1, OFF_ISTAT, 32'h3);
		irq_is(1'b0);
		apb(1'b0, 8'h1C, 32'h0);
		`CHK("unmapped", 33'h1_0000_0000, {err, rd})
		apb(1'b1, OFF_MODE, 32'h1);
		epp_en <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			v = rnd();
			dly <= i == 6 ? 4'hF : v[2:0];
			rb <= v[15:8];
			apb(i[0], OFF_EPP, v);
			#1;
			`CHK("epp err", i == 6, err)
			`CHK("epp wait", 1'b1, saw)
			`CHK("wait end", 1'b1, host_wait_line_oe_n)
			if (i % 2 == 0 && i < 6) `CHK("epp rd", {24'h0, v[15:8]}, rd)
			`CHK("wait out", 1'b0, host_wait_line_out)
			if (i[0]) `CHK("epp wr", v[7:0], port_data_bus_out)
			@(posedge pclk);
		end
		apb(1'b0, OFF_ISTAT, 32'h0);
		`CHK("epp istat", 32'hC, rd)
		epp_en <= 1'b0;
		apb(1'b1, OFF_MODE, 32'h0);
		tally_and_finish();
	end
endmodule : tb
